//--- core/dac_mode_strap_and_pin_config.v
// Mode strap, shared configuration pins and data qualification for the dual
// converter, with a register bus view of the resulting state.
//
// Contract
// [R01] A low mode strap selects serial-port mode and gives the shared pins serial functions.
// [R02] In serial-port mode a high pulse on the strap returns the serial registers to defaults.
// [R03] A high mode strap selects pin mode, taking format, power-down and phase from the pins.
// [R04] In serial-port mode the first shared pin is the serial clock driven by the host.
// [R05] In serial-port mode the second shared pin is one data line that host and device share.
// [R06] In serial-port mode the third shared pin is an active-low select framing each access.
// [R07] In pin mode the phase pin sets the retiming phase and is held at 0 for a common clock.
// [R08] In pin mode a 0 to 1 edge on the phase pin triggers the retiming alignment.
// [R09] In pin mode a low format pin means straight binary and a high one twos complement.
// [R10] In pin mode a high power-down pin stops everything except the serial port; here it freezes only sample capture and hand-off.
// [R11] Each channel's adjust pin is its auxiliary output when the internal set resistor is on.
// [R12] Parallel input data are qualified by the data qualification clock.
// [R13] Conversion timing comes from a separate sampling clock input.
// [R14] The host keeps the strap static in operation apart from the serial reset pulse.
//
// The implementer's own choices: the register addresses and the Avalon-MM slave port.
`timescale 1ns/100ps
`include "dac_cfg_defs.vh"

module dac_mode_strap_and_pin_config (
	// Clock and reset.
	input  wire                  ref_clk,
	input  wire                  rst_n,
	// Avalon-MM register slave.
	input  wire [3:0]            avs_address,
	input  wire                  avs_read,
	input  wire                  avs_write,
	input  wire [31:0]           avs_writedata,
	output reg  [31:0]           avs_readdata,
	output reg                   avs_waitrequest,
	// Mode strap and serial reset.
	input  wire                  mode_strap_reset,
	// First shared pin: serial clock or retime_phase_select.
	input  wire                  shared_clk_pin,
	// Second shared pin: serial data or format select.
	input  wire                  shared_data_in,
	output wire                  shared_data_out,
	output wire                  shared_data_oe,
	// Third shared pin: select, low active, or power_down_pin.
	input  wire                  shared_sel_pin,
	// Parallel data and its clocks.
	input  wire [`SAMPLE_W-1:0]  sample_in,
	input  wire                  data_qualify_clock,
	input  wire                  sampling_clock,
	// Resulting configuration.
	output reg                   pin_mode_q,
	output reg                   format_twos_q,
	output reg                   power_down_q,
	output reg                   retime_phase_q,
	output reg                   retime_trigger_q,
	output reg                   i_adjust_aux_q,
	output reg                   q_adjust_aux_q,
	// Converted sample toward the converters.
	output reg  [`SAMPLE_W-1:0]  sample_out_q,
	output reg                   sample_valid_q
);

	reg                  strap_q;
	reg                  phase_prev_q;
	reg                  qual_prev_q;
	reg                  samp_prev_q;
	reg [`SAMPLE_W-1:0]  hold_q;
	reg                  hold_valid_q;
	reg                  capture_en_q;
	reg [15:0]           retime_count_q;
	reg [31:0]           read_mux;
	wire                 ser_clk;
	wire                 ser_sel_n;
	wire                 ser_clear;
	wire                 reg_format_twos;
	wire                 reg_power_down;
	wire                 i_internal_set_resistor;
	wire                 q_internal_set_resistor;
	wire                 format_next;
	wire                 power_down_next;
	wire                 access;

	// Rising edge of a synchronously sampled level against its last value.
	function rising;
		input now;
		input prev;
		begin
			rising = now & ~prev;
		end
	endfunction

	// Map an input word to straight binary for the current sources.
	function [`SAMPLE_W-1:0] to_offset_binary;
		input [`SAMPLE_W-1:0] word;
		input                 twos;
		begin
			to_offset_binary = word;
			if (twos) begin
				to_offset_binary[`SAMPLE_W-1] = ~word[`SAMPLE_W-1];
			end
		end
	endfunction

	// Strap is registered once; the host is expected to keep it static.
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			strap_q <= 1'b0;
		end else begin
			strap_q <= mode_strap_reset; // see [R14]
		end
	end

	// Serial functions exist only in serial-port mode; in pin mode the
	// port sees an idle clock and a released select.
	assign ser_clk   = strap_q ? 1'b0 : shared_clk_pin; // see [R01] [R04]
	assign ser_sel_n = strap_q ? 1'b1 : shared_sel_pin; // see [R01] [R06]
	// A high strap, whether a reset pulse or pin mode, clears the
	// registers, so entering serial mode always starts from defaults.
	assign ser_clear = strap_q; // see [R02]

	serial_cfg_port u_serial (
		.ref_clk                 (ref_clk),
		.rst_n                   (rst_n),
		.regs_clear              (ser_clear),
		.ser_clk                 (ser_clk),
		.ser_data_in             (shared_data_in),
		.ser_sel_n               (ser_sel_n),
		.ser_data_out            (shared_data_out),
		.ser_data_oe             (shared_data_oe),
		.reg_format_twos         (reg_format_twos),
		.reg_power_down          (reg_power_down),
		.i_internal_set_resistor (i_internal_set_resistor),
		.q_internal_set_resistor (q_internal_set_resistor)
	);

	// In pin mode format and power-down come straight from the pins.
	assign format_next     = strap_q ? shared_data_in : reg_format_twos; // see [R03] [R09]
	assign power_down_next = strap_q ? shared_sel_pin : reg_power_down; // see [R03] [R10]

	// Mode, format, power-down and adjust pin function.
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_mode_q     <= 1'b0;
			format_twos_q  <= 1'b0;
			power_down_q   <= 1'b0;
			i_adjust_aux_q <= 1'b0;
			q_adjust_aux_q <= 1'b0;
		end else begin
			pin_mode_q     <= strap_q; // see [R01] [R03]
			format_twos_q  <= format_next; // see [R09]
			power_down_q   <= power_down_next; // see [R10]
			i_adjust_aux_q <= i_internal_set_resistor; // see [R11]
			q_adjust_aux_q <= q_internal_set_resistor; // see [R11]
		end
	end

	// Retiming phase level and its 0 to 1 trigger, only in pin mode.
	// A common clock needs no alignment, so a held 0 never triggers.
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			phase_prev_q     <= 1'b0;
			retime_phase_q   <= 1'b0;
			retime_trigger_q <= 1'b0;
			retime_count_q   <= 16'h0000;
		end else begin
			phase_prev_q     <= shared_clk_pin;
			retime_phase_q   <= strap_q & shared_clk_pin; // see [R07]
			retime_trigger_q <= 1'b0;
			if (strap_q && rising(shared_clk_pin, phase_prev_q)) begin
				retime_trigger_q <= 1'b1; // see [R08]
				retime_count_q   <= retime_count_q + 16'h0001;
			end
		end
	end

	// Data are taken on the qualification clock and handed to the
	// converters on the sampling clock; power-down freezes both, but the
	// serial port above keeps running.
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			qual_prev_q    <= 1'b0;
			samp_prev_q    <= 1'b0;
			hold_q         <= {`SAMPLE_W{1'b0}};
			hold_valid_q   <= 1'b0;
			sample_out_q   <= {`SAMPLE_W{1'b0}};
			sample_valid_q <= 1'b0;
		end else begin
			qual_prev_q    <= data_qualify_clock;
			samp_prev_q    <= sampling_clock;
			sample_valid_q <= 1'b0;
			if (!power_down_q && capture_en_q &&
			    rising(data_qualify_clock, qual_prev_q)) begin
				hold_q       <= sample_in; // see [R12]
				hold_valid_q <= 1'b1;
			end
			if (!power_down_q && hold_valid_q &&
			    rising(sampling_clock, samp_prev_q)) begin
				sample_out_q   <= to_offset_binary(hold_q, format_twos_q); // see [R13] [R09]
				sample_valid_q <= 1'b1; // see [R13]
			end
		end
	end

	// Read data for the addressed register; unmapped offsets read zero.
	always @* begin
		read_mux = 32'h0000_0000;
		case (avs_address)
		`OFS_CONTROL: begin
			read_mux[`CTRL_CAPTURE_EN] = capture_en_q;
		end
		`OFS_STATUS: begin
			read_mux[`STAT_PIN_MODE]     = pin_mode_q;
			read_mux[`STAT_FORMAT_TWOS]  = format_twos_q;
			read_mux[`STAT_POWER_DOWN]   = power_down_q;
			read_mux[`STAT_RETIME_PHASE] = retime_phase_q;
			read_mux[`STAT_I_AUX]        = i_adjust_aux_q;
			read_mux[`STAT_Q_AUX]        = q_adjust_aux_q;
		end
		`OFS_SAMPLE: begin
			read_mux[`SAMPLE_W-1:0] = sample_out_q;
		end
		`OFS_RETIME_COUNT: begin
			read_mux[15:0] = retime_count_q;
		end
		default: begin
			read_mux = 32'h0000_0000;
		end
		endcase
	end

	assign access = avs_read | avs_write;

	// Bus slave with one wait state: waitrequest drops for one cycle, and
	// the write lands at the edge where the master sees it low.
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			avs_waitrequest <= 1'b1;
			avs_readdata    <= 32'h0000_0000;
			capture_en_q    <= `CTRL_RESET;
		end else begin
			avs_waitrequest <= 1'b1;
			if (access && avs_waitrequest) begin
				avs_waitrequest <= 1'b0;
				if (avs_read) begin
					avs_readdata <= read_mux;
				end
			end
			if (avs_write && !avs_waitrequest &&
			    avs_address == `OFS_CONTROL) begin
				capture_en_q <= avs_writedata[`CTRL_CAPTURE_EN];
			end
		end
	end

endmodule

//--- core/serial_cfg_port.v
// Serial configuration port with its small register file.
`timescale 1ns/100ps
`include "dac_cfg_defs.vh"

module serial_cfg_port (
	// Clock and reset.
	input  wire       ref_clk,
	input  wire       rst_n,
	// Return all registers to defaults while high.
	input  wire       regs_clear,
	// Serial pins; clock and select already gated by the mode, data in taken straight from the pin.
	input  wire       ser_clk,
	input  wire       ser_data_in,
	input  wire       ser_sel_n,
	output reg        ser_data_out,
	output reg        ser_data_oe,
	// Register fields used by the rest of the block.
	output wire       reg_format_twos,
	output wire       reg_power_down,
	output wire       i_internal_set_resistor,
	output wire       q_internal_set_resistor
);

	reg [7:0] regs_q [0:`SER_REG_COUNT-1];
	reg       clk_prev_q;
	reg [4:0] bit_cnt_q;
	reg [7:0] instr_q;
	reg [7:0] shift_q;
	wire      clk_rise;
	wire      clk_fall;
	wire      is_read;
	integer   i;

	assign clk_rise = ser_clk & ~clk_prev_q;
	assign clk_fall = ~ser_clk & clk_prev_q;
	assign is_read  = instr_q[`SER_READ_BIT];

	// Frame engine: eight instruction bits then eight data bits, MSB first.
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			clk_prev_q   <= 1'b0;
			bit_cnt_q    <= 5'h00;
			instr_q      <= 8'h00;
			shift_q      <= 8'h00;
			ser_data_out <= 1'b0;
			ser_data_oe  <= 1'b0;
			for (i = 0; i < `SER_REG_COUNT; i = i + 1) begin
				regs_q[i] <= `SREG_OTHER_RST;
			end
			regs_q[`SREG_DATA_CTRL] <= `SREG_DATA_CTRL_RST;
			regs_q[`SREG_SET_RES]   <= `SREG_SET_RES_RST;
		end else begin
			clk_prev_q <= ser_clk;
			if (regs_clear) begin // see [R02]
				for (i = 0; i < `SER_REG_COUNT; i = i + 1) begin
					regs_q[i] <= `SREG_OTHER_RST;
				end
				regs_q[`SREG_DATA_CTRL] <= `SREG_DATA_CTRL_RST;
				regs_q[`SREG_SET_RES]   <= `SREG_SET_RES_RST;
			end
			if (ser_sel_n) begin // see [R06]
				// Deselect aborts a partial frame and frees the data line.
				bit_cnt_q   <= 5'h00;
				ser_data_oe <= 1'b0;
			end else if (clk_rise && bit_cnt_q < `SER_FRAME_BITS) begin
				// Bits are taken on the rising serial clock edge.
				bit_cnt_q <= bit_cnt_q + 5'h01; // see [R04]
				if (bit_cnt_q <= `SER_INSTR_LAST) begin
					instr_q <= {instr_q[6:0], ser_data_in};
				end else if (!is_read) begin
					// A read's data phase must not disturb the outgoing
					// bits, so nothing is shifted in while reading.
					shift_q <= {shift_q[6:0], ser_data_in};
				end
				if (bit_cnt_q == `SER_INSTR_LAST && ser_data_in == 1'b0 &&
				    instr_q[6] == 1'b0) begin
					ser_data_oe <= 1'b0;
				end
				if (bit_cnt_q == `SER_FRAME_BITS - 5'h01 && !is_read &&
				    !regs_clear) begin
					regs_q[instr_q[2:0]] <= {shift_q[6:0], ser_data_in};
				end
			end else if (clk_fall && bit_cnt_q >= `SER_INSTR_LAST + 5'h01 &&
			             bit_cnt_q < `SER_FRAME_BITS && is_read) begin
				// Device drives the shared line only in a read's data phase.
				ser_data_oe <= 1'b1; // see [R05]
				if (bit_cnt_q == `SER_INSTR_LAST + 5'h01) begin
					ser_data_out <= regs_q[instr_q[2:0]][7];
					shift_q      <= {regs_q[instr_q[2:0]][6:0], 1'b0};
				end else begin
					ser_data_out <= shift_q[7];
					shift_q      <= {shift_q[6:0], 1'b0};
				end
			end else if (bit_cnt_q == `SER_FRAME_BITS && clk_fall) begin
				// Turn the line back to the host after the last bit.
				ser_data_oe <= 1'b0; // see [R05]
			end
		end
	end

	assign reg_format_twos = regs_q[`SREG_DATA_CTRL][`SDATA_FORMAT_TWOS];
	assign reg_power_down  = regs_q[`SREG_DATA_CTRL][`SDATA_POWER_DOWN];
	assign i_internal_set_resistor = regs_q[`SREG_SET_RES][`SSET_I_INTERNAL];
	assign q_internal_set_resistor = regs_q[`SREG_SET_RES][`SSET_Q_INTERNAL];

endmodule

//--- include/dac_cfg_defs.vh
// Constants for the converter mode strap and shared pin configuration block.
`ifndef DAC_CFG_DEFS_VH
`define DAC_CFG_DEFS_VH

// Register bus byte offsets.
`define OFS_CONTROL        4'h0
`define OFS_STATUS         4'h4
`define OFS_SAMPLE         4'h8
`define OFS_RETIME_COUNT   4'hc

// Control register fields and reset value.
`define CTRL_CAPTURE_EN    0
`define CTRL_RESET         1'h1

// Status register field positions.
`define STAT_PIN_MODE      0
`define STAT_FORMAT_TWOS   1
`define STAT_POWER_DOWN    2
`define STAT_RETIME_PHASE  3
`define STAT_I_AUX         4
`define STAT_Q_AUX         5

// Sample width of the parallel data port.
`define SAMPLE_W           14

// Serial port frame layout.
`define SER_FRAME_BITS     5'h10
`define SER_INSTR_LAST     5'h07
`define SER_READ_BIT       7
`define SER_REG_COUNT      8

// Serial port register indices, fields and reset values.
`define SREG_DATA_CTRL     3'h0
`define SREG_SET_RES       3'h1
`define SDATA_FORMAT_TWOS  0
`define SDATA_POWER_DOWN   1
`define SSET_I_INTERNAL    0
`define SSET_Q_INTERNAL    1
`define SREG_DATA_CTRL_RST 8'h00
`define SREG_SET_RES_RST   8'h00
`define SREG_OTHER_RST     8'h00

`endif

//--- verif/cfg_host_model.sv
// Host model driving the strap and the three shared configuration pins.
`timescale 1ns/100ps
module cfg_host_model (
	// Clock.
	input  wire ref_clk,
	// Device side of the shared data line.
	input  wire shared_data_out,
	input  wire shared_data_oe,
	// Pins as the device sees them.
	output reg  mode_strap_reset,
	output reg  shared_clk_pin,
	output wire shared_data_in,
	output reg  shared_sel_pin
);
	reg hbit;
	reg hoe;

	// A released line shows the inverse of the last host bit, never a
	// kept value, so a device that samples too late reads garbage.
	assign shared_data_in = shared_data_oe ? shared_data_out :
		(hoe ? hbit : ~hbit);

	// Idle: serial mode, deselected, phase pin low.
	initial begin
		mode_strap_reset = 1'b0;
		shared_clk_pin = 1'b0;
		shared_sel_pin = 1'b1;
		hbit = 1'b0;
		hoe = 1'b0;
	end

	task tick(input integer n);
		repeat (n) @(posedge ref_clk);
	endtask

	// One 16 bit frame; each clock level lasts at least two cycles.
	task frame(input rd, input [2:0] idx, input [7:0] wd,
		output [7:0] rdv);
		reg [15:0] w;
		integer i;
		w = {rd, 4'h0, idx, wd};
		rdv = 8'h00;
		shared_sel_pin <= 1'b0;
		hoe <= 1'b1;
		tick(2);
		for (i = 15; i >= 0; i = i - 1) begin
			hbit <= w[i];
			hoe <= !(rd && i < 8);
			shared_clk_pin <= 1'b0;
			tick(2);
			shared_clk_pin <= 1'b1;
			tick(2);
			@(negedge ref_clk);
			if (i < 8)
				rdv[i] = shared_data_in;
			@(posedge ref_clk);
		end
		shared_clk_pin <= 1'b0;
		tick(2);
		shared_sel_pin <= 1'b1;
		hoe <= 1'b0;
		tick(2);
	endtask

	// Pin mode levels on the data and select pins.
	task set_pins(input fmt, input pdn);
		hoe <= 1'b1;
		hbit <= fmt;
		shared_sel_pin <= pdn;
		tick(1);
	endtask

	task set_strap(input v);
		mode_strap_reset <= v;
		tick(4);
	endtask

	task pulse_strap;
		mode_strap_reset <= 1'b1;
		tick(2);
		mode_strap_reset <= 1'b0;
		tick(2);
	endtask

	task phase_pulse;
		shared_clk_pin <= 1'b1;
		tick(3);
		shared_clk_pin <= 1'b0;
		tick(3);
	endtask
endmodule

//--- verif/dac_cfg_chk.sv
// Concurrent checks on the ports of the configuration block.
`timescale 1ns/100ps
module dac_cfg_chk (
	// Clock and reset.
	input wire ref_clk,
	input wire rst_n,
	// Register bus handshake.
	input wire avs_read,
	input wire avs_write,
	input wire avs_waitrequest,
	// Strap and shared pins.
	input wire mode_strap_reset,
	input wire shared_clk_pin,
	input wire shared_data_in,
	input wire shared_data_oe,
	input wire shared_sel_pin,
	// Resulting configuration.
	input wire pin_mode_q,
	input wire format_twos_q,
	input wire power_down_q,
	input wire retime_phase_q,
	input wire retime_trigger_q,
	input wire sample_valid_q
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);

	// The slave answers one cycle after a request, for one cycle only.
	bus_wait_a: assert property ((avs_read || avs_write) && avs_waitrequest
		|=> !avs_waitrequest) else $error("bus answer late");
	bus_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("bus answer stretched");
	// Mode lags the strap by two edges; a stuck mode register shows here.
	mode_track_a: assert property ($past(rst_n, 2) |->
		pin_mode_q == $past(mode_strap_reset, 2))
		else $error("mode does not follow strap");
	// Pin levels held for three cycles must have reached the outputs.
	fmt_twos_a: assert property ((pin_mode_q && shared_data_in)[*3]
		|-> format_twos_q) else $error("format not twos");
	fmt_binary_a: assert property ((pin_mode_q && !shared_data_in)[*3]
		|-> !format_twos_q) else $error("format not binary");
	pdn_pin_a: assert property ((pin_mode_q && shared_sel_pin)[*3]
		|-> power_down_q) else $error("power down missed");
	// One retiming pulse per rising phase pin edge.
	trig_edge_a: assert property (pin_mode_q && $rose(shared_clk_pin)
		|-> ##[1:2] retime_trigger_q) else $error("retime pulse missing");
	trig_pulse_a: assert property (retime_trigger_q |=> !retime_trigger_q)
		else $error("retime pulse too long");
	// Serial clock activity must never look like a phase edge.
	serial_phase_a: assert property ((!pin_mode_q)[*3]
		|-> !retime_phase_q && !retime_trigger_q)
		else $error("phase active in serial mode");
	// The device drives the data line only inside a selected serial frame.
	oe_pin_a: assert property (pin_mode_q |-> !shared_data_oe)
		else $error("data line driven in pin mode");
	oe_sel_a: assert property (shared_sel_pin[*3] |-> !shared_data_oe)
		else $error("data line driven unselected");
	valid_pulse_a: assert property (sample_valid_q |=> !sample_valid_q)
		else $error("sample valid too long");
endmodule

bind dac_mode_strap_and_pin_config dac_cfg_chk chk (.ref_clk, .rst_n,
	.avs_read, .avs_write, .avs_waitrequest, .mode_strap_reset,
	.shared_clk_pin, .shared_data_in, .shared_data_oe, .shared_sel_pin,
	.pin_mode_q, .format_twos_q, .power_down_q, .retime_phase_q,
	.retime_trigger_q, .sample_valid_q);

//--- verif/dac_mode_strap_and_pin_config_tb_top.sv
// Self-checking bench for the strap and shared pin configuration block.
`timescale 1ns/100ps
`include "dac_cfg_defs.vh"
module dac_mode_strap_and_pin_config_tb_top;
	reg                  ref_clk;
	reg                  rst_n;
	reg  [3:0]           avs_address;
	reg                  avs_read;
	reg                  avs_write;
	reg  [31:0]          avs_writedata;
	wire [31:0]          avs_readdata;
	wire                 avs_waitrequest;
	wire                 mode_strap_reset;
	wire                 shared_clk_pin;
	wire                 shared_data_in;
	wire                 shared_data_out;
	wire                 shared_data_oe;
	wire                 shared_sel_pin;
	reg  [`SAMPLE_W-1:0] sample_in;
	reg                  data_qualify_clock;
	reg                  sampling_clock;
	wire [`SAMPLE_W-1:0] sample_out_q;
	integer              num_errors;
	integer              n_compared;
	integer              k;
	reg  [31:0]          q;
	reg  [31:0]          c0;
	reg  [7:0]           v;
	reg  [7:0]           r;

	dac_mode_strap_and_pin_config uut (.ref_clk, .rst_n, .avs_address,
		.avs_read, .avs_write, .avs_writedata, .avs_readdata,
		.avs_waitrequest, .mode_strap_reset, .shared_clk_pin,
		.shared_data_in, .shared_data_out, .shared_data_oe, .shared_sel_pin,
		.sample_in, .data_qualify_clock, .sampling_clock, .pin_mode_q(),
		.format_twos_q(), .power_down_q(), .retime_phase_q(),
		.retime_trigger_q(), .i_adjust_aux_q(), .q_adjust_aux_q(),
		.sample_out_q, .sample_valid_q());
	cfg_host_model host (.ref_clk, .shared_data_out, .shared_data_oe,
		.mode_strap_reset, .shared_clk_pin, .shared_data_in, .shared_sel_pin);

	// Free-running 100 MHz clock.
	always #5 ref_clk = ~ref_clk;

	task tick(input integer n);
		repeat (n) @(posedge ref_clk);
	endtask

	task chk(input string nm, input [31:0] e, input [31:0] g);
		n_compared = n_compared + 1;
		if (g !== e) begin
			num_errors = num_errors + 1;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask

	task wrap_up;
		$display("compared %0d mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// One bus access; the request holds until waitrequest is seen low.
	// Waitrequest and read data are sampled at rising edges only.
	task bus(input wr, input [3:0] a, input [31:0] d);
		integer n;
		n = 0;
		@(posedge ref_clk);
		avs_address <= a;
		avs_write <= wr;
		avs_read <= !wr;
		avs_writedata <= d;
		@(posedge ref_clk);
		while (avs_waitrequest !== 1'b0 && n < 40) begin
			@(posedge ref_clk);
			n = n + 1;
		end
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		chk("bus answer", 1, n < 40);
	endtask

	function [31:0] stat(input pm, fmt, pd, ph, ia, qa);
		stat = {26'h0, qa, ia, ph, pd, fmt, pm};
	endfunction

	// Twos complement input becomes offset binary by flipping the top bit.
	function [13:0] conv(input [13:0] w, input t);
		conv = t ? {~w[13], w[12:0]} : w;
	endfunction

	// The word is latched by the qualify clock, then junk replaces it.
	task sample_chk(input [13:0] w, input fmt);
		host.set_pins(fmt, 1'b0);
		tick(3);
		sample_in <= w;
		data_qualify_clock <= 1'b1;
		tick(2);
		data_qualify_clock <= 1'b0;
		sample_in <= ~w;
		tick(2);
		sampling_clock <= 1'b1;
		tick(2);
		sampling_clock <= 1'b0;
		tick(3);
		chk("sample out", conv(w, fmt), sample_out_q);
		bus(0, `OFS_SAMPLE, 0);
		chk("sample reg", conv(w, fmt), q);
	endtask

	// Hang guard, well beyond the expected run length.
	initial begin
		repeat (30000) @(posedge ref_clk);
		num_errors = num_errors + 1;
		wrap_up;
	end

	// Main sequence.
	initial begin
		ref_clk = 1'b0;
		rst_n = 1'b0;
		avs_address = 4'h0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		sample_in = 14'h0;
		data_qualify_clock = 1'b0;
		sampling_clock = 1'b0;
		num_errors = 0;
		n_compared = 0;
		k = $urandom(37);
		tick(16);
		rst_n <= 1'b1;
		bus(0, `OFS_CONTROL, 0);
		chk("control", 1, q);
		bus(1, `OFS_STATUS, 32'hff);
		bus(0, `OFS_STATUS, 0);
		chk("status", 0, q);
		bus(0, 4'h2, 0);
		chk("unmapped", 0, q);
		bus(1, `OFS_CONTROL, 0);
		bus(0, `OFS_CONTROL, 0);
		chk("control", 0, q);
		bus(1, `OFS_CONTROL, 1);
		$display("test registers done");
		for (k = 0; k < 4; k = k + 1) begin
			v = (k == 0) ? 8'hff : 8'($urandom);
			host.frame(0, 3'h1, {6'h0, v[1:0]}, r);
			host.frame(0, 3'h0, {6'h0, v[3:2]}, r);
			host.frame(0, 3'h5, v, r);
			host.frame(1, 3'h5, 8'h0, r);
			chk("serial read", v, r);
			bus(0, `OFS_STATUS, 0);
			chk("status", stat(0, v[2], v[3], 0, v[0], v[1]), q);
		end
		$display("test serial done");
		host.pulse_strap;
		bus(0, `OFS_STATUS, 0);
		chk("status cleared", 0, q);
		host.frame(1, 3'h5, 8'h0, r);
		chk("serial cleared", 0, r);
		$display("test strap pulse done");
		host.set_strap(1'b1);
		for (k = 0; k < 8; k = k + 1) begin
			v = 8'($urandom);
			host.set_pins(v[0], v[1]);
			tick(4);
			bus(0, `OFS_STATUS, 0);
			chk("pin status", stat(1, v[0], v[1], 0, 0, 0), q);
		end
		host.set_pins(1'b0, 1'b0);
		bus(0, `OFS_RETIME_COUNT, 0);
		c0 = q;
		repeat (3) host.phase_pulse;
		bus(0, `OFS_RETIME_COUNT, 0);
		chk("retime count", (c0 + 3) & 32'hffff, q);
		$display("test pin mode done");
		for (k = 0; k < 8; k = k + 1) begin
			v = 8'($urandom);
			sample_chk((k < 2) ? {k[0], 13'h0} : 14'($urandom), v[0]);
		end
		$display("test samples done");
		wrap_up;
	end
endmodule
